// *** hdl/nand_host_pkg.sv ***
// Constants, commands and states for the NAND host sequencer.
// Assumes one 200 MHz clock and a NAND device on the far side of the pins.
package nand_host_pkg;
    localparam int CA_BITS = 12;
    localparam int PA_BITS = 6;
    localparam int BA_BITS_MAX = 11;
    localparam int ROW_BITS = PA_BITS + BA_BITS_MAX;
    localparam int CLK_PERIOD_NS = 5;
    // Strobe phase lengths in ns, rounded up to cycles
    localparam int T_LOW_NS = 10;
    localparam int T_HIGH_NS = 10;
    localparam int T_LOW_CYC = (T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_HIGH_CYC = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] C_RESET = 8'hff;
    localparam logic [7:0] C_STATUS = 8'h70;
    localparam logic [7:0] C_STATUS_ENH = 8'h78;
    // Operation codes presented by the user
    typedef enum logic [2:0] {
        OP_CMD  = 3'b000,
        OP_ADDR = 3'b001,
        OP_DIN  = 3'b010,
        OP_DOUT = 3'b011,
        OP_ROW  = 3'b100,
        OP_FULL = 3'b101
    } op_type;
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_LOW   = 3'b001,
        S_HIGH  = 3'b010,
        S_NEXT  = 3'b011,
        S_DONE  = 3'b100
    } state_type;
endpackage

// *** hdl/strobe_if.sv ***
// Strobe timer handshake between sequencer and pulse generator.
// Assumes a single clock domain.
`timescale 1ns/1ps
`default_nettype none
interface strobe_if;
    logic start;
    logic phase_low;
    logic done;
    modport ctrl (output start, input phase_low, input done);
    modport timer (input start, output phase_low, output done);
endinterface
`default_nettype wire

// *** hdl/strobe_timer.sv ***
// Generates one low then high strobe phase of fixed cycle counts.
// Assumes start is a one-cycle request from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module strobe_timer #(
    parameter int LOW_CYC  = 2,
    parameter int HIGH_CYC = 2
) (
    input  wire logic clk,
    input  wire logic rst,
    strobe_if.timer   sif
);
    localparam int CW = 8;
    logic [CW-1:0] cnt_q, cnt_d;
    logic          low_q, low_d;
    logic          act_q, act_d;
    logic          done_q, done_d;

    // Count the low phase, then the high phase
    always_comb begin
        cnt_d = cnt_q;
        low_d = low_q;
        act_d = act_q;
        done_d = 1'b0;
        if (sif.start && !act_q) begin
            act_d = 1'b1;
            low_d = 1'b1;
            cnt_d = CW'(LOW_CYC - 1);
        end else if (act_q) begin
            if (cnt_q != '0) begin
                cnt_d = cnt_q - 1'b1;
            end else if (low_q) begin
                low_d = 1'b0;
                cnt_d = CW'(HIGH_CYC - 1);
            end else begin
                act_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    // Register the timer; reset leaves the strobe idle
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
            low_q <= 1'b0;
            act_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            low_q <= low_d;
            act_q <= act_d;
            done_q <= done_d;
        end
    end

    assign sif.phase_low = low_q;
    assign sif.done = done_q;
endmodule
`default_nettype wire

// *** hdl/nand_host.sv ***
// Host sequencer that drives a NAND device over its multiplexed pins.
// Assumes the ready/busy pin and bus inputs are synchronous to REF_CLK.
`timescale 1ns/1ps
`default_nettype none
module nand_host #(
    parameter bit TWO_PLANE = 1'b1,
    parameter bit SEND_DUMMY = 1'b0
) (
    input  wire logic                           REF_CLK,
    input  wire logic                           SYS_RST,
    input  wire logic                           REQ_VALID,
    output logic                                REQ_READY,
    input  wire nand_host_pkg::op_type          REQ_OP,
    input  wire logic [7:0]                     REQ_BYTE,
    input  wire logic [nand_host_pkg::CA_BITS-1:0]  REQ_COL,
    input  wire logic [nand_host_pkg::PA_BITS-1:0]  REQ_PAGE,
    input  wire logic [nand_host_pkg::BA_BITS_MAX-1:0] REQ_BLOCK,
    input  wire logic                           REQ_LAST,
    output logic                                RSP_VALID,
    output logic [7:0]                          RSP_BYTE,
    output logic                                REJECT,
    output logic                                CE_N,
    output logic                                CLE,
    output logic                                ALE,
    output logic                                WE_N,
    output logic                                READ_STROBE_N,
    output logic                                WP_N,
    input  wire logic [7:0]                     IO_IN,
    output logic [7:0]                          IO_OUT,
    output logic                                IO_OE,
    input  wire logic                           RB_N,
    input  wire logic                           WRITE_ALLOW
);
    import nand_host_pkg::*;

    strobe_if sif();
    strobe_timer #(.LOW_CYC(T_LOW_CYC), .HIGH_CYC(T_HIGH_CYC)) u_timer (
        .clk (REF_CLK),
        .rst (SYS_RST),
        .sif (sif)
    );

    state_type       st_q, st_d;
    op_type          op_q, op_d;
    logic [7:0]      byte_q, byte_d;
    logic [39:0]     addr_q, addr_d;
    logic [2:0]      acnt_q, acnt_d;
    logic [2:0]      anum_q, anum_d;
    logic            last_q, last_d;
    logic [7:0]      rsp_q, rsp_d;
    logic            rv_q, rv_d;
    logic            rej_q, rej_d;
    logic            sel_q, sel_d;
    logic            start;
    logic [ROW_BITS-1:0] row;
    logic            busy;
    logic            cmd_ok;
    logic [2:0]      full_cycles;

    assign busy = !RB_N;
    // Row joins block bits above page bits
    assign row = {REQ_BLOCK, REQ_PAGE};
    // Two-plane needs five cycles; one-plane four plus optional dummy
    assign full_cycles = (TWO_PLANE || SEND_DUMMY) ? 3'd5 : 3'd4;

    // Every command byte of the listed sequences; a byte outside the list is
    // refused here, so a stray code from the caller never reaches the pins.
    // The order of a sequence is not checked; that stays with the caller.
    logic cmd_known;

    always_comb begin
        case (REQ_BYTE)
            8'hff, 8'h70, 8'h78:               cmd_known = 1'b1;
            8'h00, 8'h30:                      cmd_known = 1'b1;
            8'h80, 8'h10:                      cmd_known = 1'b1;
            8'h60, 8'hd0:                      cmd_known = 1'b1;
            8'h05, 8'he0, 8'h85:               cmd_known = 1'b1;
            8'h90, 8'hec, 8'hed, 8'hee, 8'hef: cmd_known = 1'b1;
            8'h35, 8'h11, 8'h81:               cmd_known = 1'b1;
            8'hd1, 8'h8b:                      cmd_known = 1'b1;
            8'h29, 8'h17, 8'h04, 8'h19:        cmd_known = 1'b1;
            8'h2a, 8'h24, 8'h23, 8'h2c, 8'h7a: cmd_known = 1'b1;
            8'h4c, 8'h03, 8'h1d, 8'h41:        cmd_known = 1'b1;
            default:                           cmd_known = 1'b0;
        endcase
    end

    // Unlisted command bytes never go out; while busy commands are limited to reset and status, and data reads are refused
    always_comb begin
        cmd_ok = 1'b1;
        if (REQ_OP == OP_CMD && !cmd_known) begin
            cmd_ok = 1'b0;
        end else if (busy && REQ_OP == OP_CMD) begin
            cmd_ok = (REQ_BYTE == C_RESET) || (REQ_BYTE == C_STATUS) || (REQ_BYTE == C_STATUS_ENH);
        end else if (busy && REQ_OP == OP_DOUT) begin
            cmd_ok = 1'b0;
        end
    end

    assign REQ_READY = (st_q == S_IDLE);
    assign start = (st_q == S_LOW) || (st_q == S_NEXT);
    assign sif.start = start;

    // Sequencer: take a request, emit one or more strobe cycles
    always_comb begin
        st_d = st_q;
        op_d = op_q;
        byte_d = byte_q;
        addr_d = addr_q;
        acnt_d = acnt_q;
        anum_d = anum_q;
        last_d = last_q;
        rsp_d = rsp_q;
        rv_d = 1'b0;
        rej_d = 1'b0;
        sel_d = sel_q;
        case (st_q)
            S_IDLE: begin
                if (REQ_VALID) begin
                    if (!cmd_ok) begin
                        rej_d = 1'b1;
                    end else begin
                        op_d = REQ_OP;
                        last_d = REQ_LAST;
                        byte_d = REQ_BYTE;
                        acnt_d = 3'd0;
                        sel_d = 1'b1;
                        // Column low, column high with top lines low,
                        // page plus block low, block mid, block bit 10
                        addr_d = {7'h00, REQ_BLOCK[10], row[ROW_BITS-2:PA_BITS+2],
                                  REQ_BLOCK[1:0], REQ_PAGE, 4'h0, REQ_COL[11:8],
                                  REQ_COL[7:0]};
                        case (REQ_OP)
                            OP_ADDR: anum_d = 3'd1;
                            OP_ROW: begin
                                anum_d = TWO_PLANE ? 3'd3 : 3'd2;
                                addr_d = {16'h0000, 7'h00, REQ_BLOCK[10], row[ROW_BITS-2:PA_BITS+2],
                                          REQ_BLOCK[1:0], REQ_PAGE};
                            end
                            OP_FULL: anum_d = full_cycles;
                            default: anum_d = 3'd1;
                        endcase
                        if (REQ_OP == OP_ADDR) begin
                            addr_d = {32'h0, REQ_BYTE};
                        end
                        st_d = S_LOW;
                    end
                end
            end
            S_LOW, S_NEXT: begin
                st_d = S_HIGH;
            end
            S_HIGH: begin
                // Sample the bus while the read strobe is still low; once it
                // rises the device may already have let the lines go.
                // Limitation: the device's access time must fit one low phase.
                if (op_q == OP_DOUT && sif.phase_low) begin
                    rsp_d = IO_IN;
                end
                if (sif.done) begin
                    if (op_q == OP_DOUT) begin
                        rv_d = 1'b1;
                    end
                    if ((op_q == OP_ADDR || op_q == OP_ROW || op_q == OP_FULL) && acnt_q + 3'd1 < anum_q) begin
                        acnt_d = acnt_q + 3'd1;
                        addr_d = {8'h00, addr_q[39:8]};
                        st_d = S_NEXT;
                    end else begin
                        st_d = S_DONE;
                    end
                end
            end
            S_DONE: begin
                if (last_q) begin
                    sel_d = 1'b0;
                end
                st_d = S_IDLE;
            end
            default: st_d = S_IDLE;
        endcase
    end

    // Register every sequencer field; reset leaves the pins in standby
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            st_q <= S_IDLE;
            op_q <= OP_CMD;
            byte_q <= 8'h00;
            addr_q <= 40'h0;
            acnt_q <= 3'd0;
            anum_q <= 3'd0;
            last_q <= 1'b0;
            rsp_q <= 8'h00;
            rv_q <= 1'b0;
            rej_q <= 1'b0;
            sel_q <= 1'b0;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            byte_q <= byte_d;
            addr_q <= addr_d;
            acnt_q <= acnt_d;
            anum_q <= anum_d;
            last_q <= last_d;
            rsp_q <= rsp_d;
            rv_q <= rv_d;
            rej_q <= rej_d;
            sel_q <= sel_d;
        end
    end

    // A bus cycle is in flight in every state that owns the strobe timer
    logic in_cyc;
    logic wr_op;
    assign in_cyc = (st_q == S_HIGH) || (st_q == S_LOW) || (st_q == S_NEXT);
    assign wr_op = (op_q != OP_DOUT);

    // Pin drive; strobes idle high, select high means standby
    always_comb begin
        CE_N = !sel_q;
        CLE = in_cyc && (op_q == OP_CMD);
        ALE = in_cyc && (op_q == OP_ADDR || op_q == OP_ROW || op_q == OP_FULL);
        WE_N = !(in_cyc && wr_op && sif.phase_low);
        READ_STROBE_N = !(in_cyc && !wr_op && sif.phase_low && !busy);
        IO_OE = sel_q && in_cyc && wr_op;
        IO_OUT = (op_q == OP_CMD || op_q == OP_DIN) ? byte_q : addr_q[7:0];
    end

    // Guard follows the live allow input, never latched per strobe
    assign WP_N = WRITE_ALLOW;
    assign RSP_BYTE = rsp_q;
    assign RSP_VALID = rv_q;
    assign REJECT = rej_q;

    // Command strobe and address strobe never overlap
    strobe_excl_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        !(CLE && ALE)) else $error("command and address strobe together");
    we_cle_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (!WE_N && op_q == OP_CMD) |-> (CLE && !ALE && !CE_N && READ_STROBE_N))
        else $error("command write without proper strobes");
    we_ale_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (!WE_N && ALE) |-> (!CLE && !CE_N && READ_STROBE_N))
        else $error("address write without proper strobes");
    data_in_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (!WE_N && op_q == OP_DIN) |-> (!CLE && !ALE && !CE_N))
        else $error("data input with latch strobe high");
    data_out_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        !READ_STROBE_N |-> (WE_N && !CLE && !ALE && !CE_N && !IO_OE))
        else $error("read strobe with bad controls");
    busy_re_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        busy |-> READ_STROBE_N) else $error("read strobe low while busy");
    standby_oe_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        CE_N |-> !IO_OE) else $error("bus driven while deselected");
    wp_live_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        WP_N == WRITE_ALLOW) else $error("write guard not live");
    busy_cmd_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (REQ_VALID && REQ_READY && busy && REQ_OP == OP_CMD && !cmd_ok) |=> REJECT)
        else $error("busy command not refused");
    cyc_len_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        $fell(WE_N) |-> !WE_N[*2] ##1 WE_N) else $error("write strobe width wrong");

    // Refused requests never start a transfer
    unlisted_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (REQ_VALID && REQ_READY && REQ_OP == OP_CMD && !cmd_known) |=> (REJECT && st_q == S_IDLE))
        else $error("unlisted command not refused");
    busy_read_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (REQ_VALID && REQ_READY && busy && REQ_OP == OP_DOUT) |=> (REJECT && st_q == S_IDLE))
        else $error("read while busy not refused");

    // Address byte layout: unused upper lines stay low, cycle count bounded
    col_high_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (!WE_N && ALE && op_q == OP_FULL && acnt_q == 3'd1) |-> (IO_OUT[7:4] == 4'h0))
        else $error("column high byte upper lines not low");
    block_top_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (!WE_N && ALE && op_q == OP_FULL && acnt_q == 3'd4) |-> (IO_OUT[7:1] == 7'h00))
        else $error("fifth address byte upper lines not low");
    addr_count_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (st_q == S_NEXT) |-> (acnt_q != 3'd0 && acnt_q < anum_q && anum_q <= full_cycles))
        else $error("address cycle count out of range");

    // One read pulse per data output request; bus owned for writes only
    re_pulse_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        $fell(READ_STROBE_N) |=> !READ_STROBE_N ##1 READ_STROBE_N[*3])
        else $error("read strobe pulse shape wrong");
    rsp_done_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        RSP_VALID |-> (st_q == S_DONE && op_q == OP_DOUT))
        else $error("read data flagged outside a read");
    oe_write_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (in_cyc && wr_op) |-> IO_OE)
        else $error("bus not driven during a write cycle");
    select_hold_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        in_cyc |-> !CE_N) else $error("select released inside a bus cycle");

    // Main scenarios: command, full address, read, refusal, program data
    prog_c: cover property (@(posedge REF_CLK) disable iff (SYS_RST)
        (!WE_N && op_q == OP_DIN));
    cmd_c: cover property (@(posedge REF_CLK) disable iff (SYS_RST) $rose(CLE));
    full_c: cover property (@(posedge REF_CLK) disable iff (SYS_RST)
        (st_q == S_NEXT && acnt_q == 3'd4));
    rd_c: cover property (@(posedge REF_CLK) disable iff (SYS_RST) RSP_VALID);
    rej_c: cover property (@(posedge REF_CLK) disable iff (SYS_RST) REJECT);
endmodule
`default_nettype wire

// *** testbench/nand_dev_model.sv ***
// Device model: logs every latched byte except data bytes while the guard is low, serves reads and shows busy.
// Assumes host pins change just after clk edges; clk only samples them.
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model #(
    parameter int BUSY_CYC = 60
) (
    input  wire logic       clk,
    input  wire logic       ce_n,
    input  wire logic       cle,
    input  wire logic       ale,
    input  wire logic       we_n,
    input  wire logic       re_n,
    input  wire logic       wp_n,
    input  wire logic [7:0] io_out,
    input  wire logic       io_oe,
    output logic      [7:0] io_in,
    output logic            rb_n
);
    logic [9:0]  log_q[$];
    logic [11:0] col_q  = 12'h000;
    logic [7:0]  last_q = 8'h00;
    logic [7:0]  cmd_q  = 8'h00;
    logic [1:0]  acnt_q = 2'h0;
    logic        we_q   = 1'b1;
    logic        re_q   = 1'b1;
    int          busy_q = 0;
    int          mods_q = 0;
    // Ready only while no internal operation runs
    assign rb_n = (busy_q == 0);
    // Idle or deselected bus shows the inverse of the last byte, never a stale copy
    assign io_in = (!ce_n && !re_n) ? last_q : ~last_q;
    // Strobe edges found by sampling each clk; kind 0 in the log marks a bad cycle
    always @(posedge clk) begin
        we_q <= we_n;
        re_q <= re_n;
        if (busy_q > 0) busy_q <= busy_q - 1;
        if (!ce_n && we_n && !we_q) begin
            if (!re_n || !io_oe) log_q.push_back({2'd0, io_out});
            else if (cle && !ale) begin
                if (busy_q > 0 && io_out != 8'hff && io_out != 8'h70 && io_out != 8'h78)
                    log_q.push_back({2'd0, io_out});
                else
                    log_q.push_back({2'd1, io_out});
                cmd_q <= io_out;
                acnt_q <= 2'h0;
                if (io_out == 8'h30) busy_q <= BUSY_CYC;
                // Guard is a live level, so a low guard blocks the start itself
                if (wp_n && (io_out == 8'h10 || io_out == 8'hd0)) begin
                    mods_q <= mods_q + 1;
                    busy_q <= BUSY_CYC;
                end
            end else if (ale && !cle) begin
                log_q.push_back({2'd2, io_out});
                if (acnt_q == 2'h0) col_q[7:0] <= io_out;
                if (acnt_q == 2'h1) col_q[11:8] <= io_out[3:0];
                if (acnt_q != 2'h3) acnt_q <= acnt_q + 2'h1;
            end else if (!ale && !cle) begin
                if (wp_n) log_q.push_back({2'd3, io_out});
            end else
                log_q.push_back({2'd0, io_out});
        end
        // Each read-strobe fall loads the next byte; reading while busy is flagged
        if (!ce_n && !re_n && re_q) begin
            if (busy_q > 0 || !we_n || cle || ale) log_q.push_back(10'h0ee);
            last_q <= (cmd_q == 8'h70) ? 8'he0 : (col_q[7:0] ^ 8'h3c);
            if (cmd_q != 8'h70) col_q <= col_q + 12'h001;
        end
    end
endmodule
`default_nettype wire

// *** testbench/nand_host_tb.sv ***
// Self-checking bench for the NAND host sequencer against the device model.
// Assumes the default two-plane build and a 200 MHz reference clock.
`timescale 1ns/1ps
`default_nettype none
module nand_host_tb;
    import nand_host_pkg::*;
    logic                   REF_CLK = 1'b0;
    logic                   SYS_RST = 1'b1;
    logic                   REQ_VALID = 1'b0;
    logic                   REQ_LAST = 1'b0;
    logic                   WRITE_ALLOW = 1'b1;
    op_type                 REQ_OP = OP_CMD;
    logic [7:0]             REQ_BYTE = 8'h00;
    logic [CA_BITS-1:0]     REQ_COL = '0, col = '0;
    logic [PA_BITS-1:0]     REQ_PAGE = '0, pg = '0;
    logic [BA_BITS_MAX-1:0] REQ_BLOCK = '0, blk = '0;
    logic [7:0]             RSP_BYTE, IO_OUT, IO_IN, byte_s, d;
    logic                   REQ_READY, RSP_VALID, REJECT, CE_N, CLE, ALE, WE_N, READ_STROBE_N, WP_N, IO_OE, RB_N;
    logic                   rej_s, rsp_s;
    int                     error_cnt = 0;
    int                     n_checks = 0;
    int                     k, n, m;
    logic [7:0] cl [19] = '{8'h90, 8'hec, 8'hed, 8'hee, 8'hef, 8'h2a, 8'h24, 8'h23, 8'h2c, 8'h7a,
                           8'h29, 8'h17, 8'h04, 8'h19, 8'h4c, 8'h03, 8'h1d, 8'h41, 8'h80};
    int         na [19] = '{1, 1, 1, 1, 1, 0, 3, 3, 0, 3, 0, 0, 0, 0, 0, 0, 0, 0, 5};

    nand_host uut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
        .REQ_OP(REQ_OP), .REQ_BYTE(REQ_BYTE), .REQ_COL(REQ_COL), .REQ_PAGE(REQ_PAGE), .REQ_BLOCK(REQ_BLOCK),
        .REQ_LAST(REQ_LAST), .RSP_VALID(RSP_VALID), .RSP_BYTE(RSP_BYTE), .REJECT(REJECT), .CE_N(CE_N),
        .CLE(CLE), .ALE(ALE), .WE_N(WE_N), .READ_STROBE_N(READ_STROBE_N), .WP_N(WP_N), .IO_IN(IO_IN),
        .IO_OUT(IO_OUT), .IO_OE(IO_OE), .RB_N(RB_N), .WRITE_ALLOW(WRITE_ALLOW));
    nand_dev_model dev (.clk(REF_CLK), .ce_n(CE_N), .cle(CLE), .ale(ALE), .we_n(WE_N), .re_n(READ_STROBE_N),
        .wp_n(WP_N), .io_out(IO_OUT), .io_oe(IO_OE), .io_in(IO_IN), .rb_n(RB_N));

    initial forever #2.5 REF_CLK = ~REF_CLK;

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Expected bus byte of address cycle n for the current column, page and block
    function automatic logic [7:0] abyte(input int n);
        case (n)
            0: return col[7:0];
            1: return {4'h0, col[11:8]};
            2: return {blk[1:0], pg};
            3: return blk[9:2];
            default: return {7'h00, blk[10]};
        endcase
    endfunction

    // Oldest byte the device latched must match kind and value
    task automatic lg(input logic [1:0] kd, input logic [7:0] b);
        logic [9:0] g;
        g = (dev.log_q.size() > 0) ? dev.log_q.pop_front() : 10'h3ff;
        check(16'(g), 16'({kd, b}), "latched byte");
    endtask

    // One request: held until taken, then watched until the sequencer is idle again
    task automatic send(input op_type op, input logic [7:0] b, input logic last);
        int i;
        rej_s = 1'b0;
        rsp_s = 1'b0;
        @(posedge REF_CLK);
        REQ_VALID <= 1'b1;
        REQ_OP <= op;
        REQ_BYTE <= b;
        REQ_LAST <= last;
        REQ_COL <= col;
        REQ_PAGE <= pg;
        REQ_BLOCK <= blk;
        @(negedge REF_CLK);
        for (i = 0; i < 100 && REQ_READY !== 1'b1; i++) @(negedge REF_CLK);
        if (REQ_READY !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %0t request never taken", $time);
            conclude();
        end
        @(posedge REF_CLK);
        REQ_VALID <= 1'b0;
        for (i = 0; i < 100; i++) begin
            @(negedge REF_CLK);
            if (REJECT === 1'b1) rej_s = 1'b1;
            if (RSP_VALID === 1'b1) begin
                rsp_s = 1'b1;
                byte_s = RSP_BYTE;
            end
            if (i > 0 && REQ_READY === 1'b1) break;
        end
        if (i == 100) begin
            error_cnt++;
            $display("[FAIL] %0t request hang", $time);
            conclude();
        end
    endtask

    task automatic wait_rdy();
        int i;
        for (i = 0; i < 300 && RB_N !== 1'b1; i++) @(negedge REF_CLK);
        if (RB_N !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %0t busy never ended", $time);
            conclude();
        end
    endtask

    initial begin
        void'($urandom(32'h56d2));
        repeat (20) @(posedge REF_CLK);
        SYS_RST <= 1'b0;
        @(negedge REF_CLK);
        check(CE_N, 1, "select after reset");
        check(IO_OE, 0, "bus after reset");
        // A byte outside every listed sequence must be refused before the pins
        send(OP_CMD, 8'h55, 0);
        check(rej_s, 1, "unlisted command");
        // Page read at all-ones then random addresses, with the busy filter probed
        for (k = 0; k < 3; k++) begin
            col = k ? 12'($urandom) : '1;
            pg = k ? 6'($urandom) : '1;
            blk = k ? 11'($urandom) : '1;
            send(OP_CMD, 8'h00, 0);
            send(OP_FULL, 8'h00, 0);
            send(OP_CMD, 8'h30, 0);
            lg(1, 8'h00);
            for (n = 0; n < 5; n++) lg(2, abyte(n));
            lg(1, 8'h30);
            send(OP_DOUT, 8'h00, 0);
            check(rej_s, 1, "read while busy");
            send(OP_CMD, 8'h90, 0);
            check(rej_s, 1, "command while busy");
            send(OP_CMD, 8'h70, 0);
            check(rej_s, 0, "status while busy");
            lg(1, 8'h70);
            wait_rdy();
            send(OP_DOUT, 8'h00, 0);
            check(byte_s, 8'he0, "status byte");
            send(OP_CMD, 8'h00, 0);
            lg(1, 8'h00);
            m = 1 + $urandom % 4;
            for (n = 0; n < m; n++) begin
                send(OP_DOUT, 8'h00, n == m - 1);
                check({rsp_s, byte_s}, {1'b1, (col[7:0] + 8'(n)) ^ 8'h3c}, "read data");
            end
            check(CE_N, 1, "deselect after last");
        end
        // Program with the guard low then high: only the second may start
        for (k = 0; k < 2; k++) begin
            @(posedge REF_CLK);
            WRITE_ALLOW <= k[0];
            @(negedge REF_CLK);
            check(WP_N, k[0], "guard level");
            m = dev.mods_q;
            col = 12'($urandom);
            pg = 6'($urandom);
            blk = 11'($urandom);
            d = 8'($urandom);
            send(OP_CMD, 8'h80, 0);
            send(OP_FULL, 8'h00, 0);
            send(OP_DIN, d, 0);
            send(OP_CMD, 8'h10, 1);
            lg(1, 8'h80);
            for (n = 0; n < 5; n++) lg(2, abyte(n));
            if (k) lg(3, d);
            lg(1, 8'h10);
            check(16'(dev.mods_q), 16'(m + k), "program start");
            wait_rdy();
        end
        // Block erase uses the three row cycles only
        pg = 6'($urandom);
        blk = 11'($urandom);
        send(OP_CMD, 8'h60, 0);
        send(OP_ROW, 8'h00, 0);
        send(OP_CMD, 8'hd0, 1);
        lg(1, 8'h60);
        for (n = 2; n < 5; n++) lg(2, abyte(n));
        lg(1, 8'hd0);
        wait_rdy();
        // Identify, lock, one-time entry and permanent guard command bytes
        for (k = 0; k < 19; k++) begin
            send(OP_CMD, cl[k], 0);
            lg(1, cl[k]);
            for (n = 0; n < na[k]; n++) begin
                d = (cl[k] == 8'h80) ? ((n == 3) ? 8'h10 : 8'h00) : 8'($urandom);
                send(OP_ADDR, d, k == 18 && n == 4);
                lg(2, d);
            end
        end
        check(16'(dev.log_q.size()), 16'h0000, "stray bus cycles");
        conclude();
    end
endmodule
`default_nettype wire
